// >>> rtl/clock_output_config_regs.v
// clock output configuration registers, serial target port and output gating
`include "clock_output_config_regs.vh"

module clock_output_config_regs #(
  parameter [3:0] REVISION_CODE    = 4'h1,
  parameter [3:0] MAKER_CODE       = 4'h5, // arbitrary value
  parameter [9:0] DEFAULT_SWING_MV = `SWING_DEFAULT_MV
) (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_srst,
  // serial bus pins
  input  wire       i_scl,
  input  wire       i_sda,
  output reg        o_sda_out,
  output reg        o_sda_oe,
  // hardware enable and select pins
  input  wire       i_ref_enable_pin,
  input  wire       i_hcsl_a_enable_pin,
  input  wire       i_hcsl_b_enable_pin,
  input  wire       i_rate_select_low,
  input  wire       i_rate_select_high,
  // clock sources
  input  wire       i_crystal_or_clock_input,
  input  wire       i_hcsl_source,
  // clock outputs
  output wire       o_ref_clk,
  output wire       o_hcsl_out_a,
  output wire       o_hcsl_out_b,
  // differential output mode
  output reg  [1:0] o_freq_code,
  output reg        o_spread_enable,
  output reg  [9:0] o_swing_mv
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_RX    = 3'h1;
  localparam [2:0] ST_ACK   = 3'h2;
  localparam [2:0] ST_TX    = 3'h3;
  localparam [2:0] ST_TXACK = 3'h4;

  localparam [1:0] PH_ADDR  = 2'h0;
  localparam [1:0] PH_CMD   = 2'h1;
  localparam [1:0] PH_COUNT = 2'h2;
  localparam [1:0] PH_DATA  = 2'h3;

  localparam [3:0] BITS_PER_BYTE = 4'h8;
  localparam [3:0] LAST_TX_BIT   = 4'h7;

  localparam [8*`NUM_REG_BYTES-1:0] RESET_IMAGE = {
    `RST_SWING_CONTROL,
    `RST_TRANSFER_LEN,
    REVISION_CODE, MAKER_CODE,
    `RST_HCSL_ENABLES,
    `RST_SPARE,
    `RST_REF_ENABLE
  };

  // swing in millivolts for a 3-bit level code
  function [9:0] swing_for_code;
    input [2:0] code;
    begin
      swing_for_code = `SWING_BASE_MV + ({7'h00, code} * `SWING_STEP_MV);
    end
  endfunction

  // picks one byte out of the flat register image
  function [7:0] image_byte;
    input [8*`NUM_REG_BYTES-1:0] image;
    input [7:0]                  offset;
    begin
      image_byte = image[8*offset +: 8];
    end
  endfunction

  // bus pin history for edge and condition detection
  reg        scl_d;
  reg        sda_d;

  // protocol state
  reg  [2:0] state;
  reg  [1:0] phase;
  reg  [3:0] bit_cnt;
  reg  [7:0] shift;
  reg        reading;
  reg        first_tx;
  reg        master_acked;
  reg  [7:0] index;
  reg  [7:0] count_left;

  // store write port
  reg        wr_en;
  reg  [7:0] wr_index;
  reg  [7:0] wr_data;

  // select pin capture
  reg        select_taken;
  reg  [1:0] select_value;

  wire [7:0]                  rd_data;
  wire [8*`NUM_REG_BYTES-1:0] image;
  wire scl_rise = i_scl & ~scl_d;
  wire scl_fall = ~i_scl & scl_d;
  wire bus_start = scl_d & i_scl & sda_d & ~i_sda;
  wire bus_stop  = scl_d & i_scl & ~sda_d & i_sda;
  wire [7:0] ref_byte    = image_byte(image, `OFS_REF_ENABLE);
  wire [7:0] hcsl_byte   = image_byte(image, `OFS_HCSL_ENABLES);
  wire [7:0] length_byte = image_byte(image, `OFS_TRANSFER_LEN);
  wire [7:0] swing_byte  = image_byte(image, `OFS_SWING_CONTROL);

  // block reads open with the transfer length, then data from the index
  wire [7:0] tx_byte = first_tx ? length_byte : rd_data;

  wire addr_hit = (shift[7:1] == `TARGET_ADDR7);

  config_byte_store #(
    .NUM_BYTES   (`NUM_REG_BYTES),
    .RESET_IMAGE (RESET_IMAGE)
  ) u_store (
    .i_clk      (i_clk),
    .i_srst     (i_srst),
    .i_wr_en    (wr_en),
    .i_wr_index (wr_index),
    .i_wr_data  (wr_data),
    .i_rd_index (index),
    .o_rd_data  (rd_data),
    .o_image    (image)
  );

  always @(posedge i_clk)
  begin
    if (i_srst)
      {scl_d, sda_d} <= 2'h3;
    else
      {scl_d, sda_d} <= {i_scl, i_sda};
  end

  // serial target: registers sit at reset values until the first start
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state        <= ST_IDLE;
      phase        <= PH_ADDR;
      bit_cnt      <= 4'h0;
      shift        <= 8'h00;
      reading      <= 1'b0;
      first_tx     <= 1'b0;
      master_acked <= 1'b0;
      index        <= 8'h00;
      count_left   <= 8'h00;
      wr_en        <= 1'b0;
      wr_index     <= 8'h00;
      wr_data      <= 8'h00;
      o_sda_out    <= 1'b0;
      o_sda_oe     <= 1'b0;
    end
    else
    begin
      wr_en <= 1'b0;
      if (bus_stop)
      begin
        state    <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end
      else if (bus_start)
      begin
        // repeated start keeps index and mode from the command phase
        state    <= ST_RX;
        phase    <= PH_ADDR;
        bit_cnt  <= 4'h0;
        o_sda_oe <= 1'b0;
      end
      else
      begin
        case (state)
          ST_RX:
          begin
            if (scl_rise && bit_cnt != BITS_PER_BYTE)
            begin
              shift   <= {shift[6:0], i_sda};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == BITS_PER_BYTE)
            begin
              bit_cnt <= 4'h0;
              case (phase)
                PH_ADDR:
                begin
                  if (addr_hit)
                  begin
                    reading  <= shift[0];
                    first_tx <= shift[0] & (count_left == 8'h00 ? 1'b1 : 1'b0) & ~first_tx & 1'b1
                                & (phase == PH_ADDR) & ~(count_left == 8'h01);
                    phase    <= PH_CMD;
                    state    <= ST_ACK;
                    o_sda_oe <= 1'b1;
                  end
                  else
                    state <= ST_IDLE;
                end
                PH_CMD:
                begin
                  // command bit 7 set: single indexed byte; clear: block
                  index      <= {1'b0, shift[`CMD_INDEX_MSB:0]};
                  count_left <= shift[`CMD_BYTE_MODE_BIT] ? 8'h01 : 8'h00;
                  phase      <= shift[`CMD_BYTE_MODE_BIT] ? PH_DATA : PH_COUNT;
                  state      <= ST_ACK;
                  o_sda_oe   <= 1'b1;
                end
                PH_COUNT:
                begin
                  count_left <= shift;
                  phase      <= PH_DATA;
                  state      <= ST_ACK;
                  o_sda_oe   <= 1'b1;
                end
                PH_DATA:
                begin
                  if (count_left != 8'h00)
                  begin
                    // ascending index order for block writes
                    wr_en      <= 1'b1;
                    wr_index   <= index;
                    wr_data    <= shift;
                    index      <= index + 8'h01;
                    count_left <= count_left - 8'h01;
                    state      <= ST_ACK;
                    o_sda_oe   <= 1'b1;
                  end
                  else
                    state <= ST_IDLE;
                end
                default:
                  state <= ST_IDLE;
              endcase
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              if (reading)
              begin
                shift    <= tx_byte;
                o_sda_oe <= ~tx_byte[7];
                if (!first_tx)
                  index <= index + 8'h01;
                first_tx <= 1'b0;
                bit_cnt  <= 4'h0;
                state    <= ST_TX;
              end
              else
              begin
                o_sda_oe <= 1'b0;
                bit_cnt  <= 4'h0;
                state    <= ST_RX;
              end
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              if (bit_cnt == LAST_TX_BIT)
              begin
                o_sda_oe <= 1'b0;
                state    <= ST_TXACK;
              end
              else
              begin
                shift    <= {shift[6:0], 1'b0};
                o_sda_oe <= ~shift[6];
                bit_cnt  <= bit_cnt + 4'h1;
              end
            end
          end
          ST_TXACK:
          begin
            if (scl_rise)
              master_acked <= ~i_sda;
            else if (scl_fall)
            begin
              if (master_acked)
              begin
                shift    <= tx_byte;
                o_sda_oe <= ~tx_byte[7];
                if (!first_tx)
                  index <= index + 8'h01;
                first_tx <= 1'b0;
                bit_cnt  <= 4'h0;
                state    <= ST_TX;
              end
              else
                state <= ST_IDLE;
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // select pins are caught once, on the first edge after reset release
  always @(posedge i_clk)
  begin
    if (i_srst)
      {select_taken, select_value} <= {1'b0, `SEL_100_PLAIN};
    else if (!select_taken)
      {select_taken, select_value} <= {1'b1, i_rate_select_high, i_rate_select_low};
  end

  always @(posedge i_clk)
  begin
    if (i_srst)
      {o_freq_code, o_spread_enable} <= {`FREQ_100, 1'b0};
    else
      case (select_value)
        `SEL_100_PLAIN:  {o_freq_code, o_spread_enable} <= {`FREQ_100, 1'b0};
        `SEL_100_SPREAD: {o_freq_code, o_spread_enable} <= {`FREQ_100, 1'b1};
        `SEL_125:        {o_freq_code, o_spread_enable} <= {`FREQ_125, 1'b0};
        default:         {o_freq_code, o_spread_enable} <= {`FREQ_200, 1'b0};
      endcase
  end

  always @(posedge i_clk)
  begin
    if (i_srst)
      o_swing_mv <= DEFAULT_SWING_MV;
    else if (swing_byte[`SWING_SELECT_BIT])
      o_swing_mv <= swing_for_code(swing_byte[`SWING_CODE_MSB:`SWING_CODE_LSB]);
    else
      o_swing_mv <= DEFAULT_SWING_MV;
  end

  // output gating: index 0 reference, 1 output A, 2 output B
  wire [2:0] gate_src;
  wire [2:0] gate_enable;
  wire [2:0] gate_out;

  assign gate_src[0]    = i_crystal_or_clock_input;
  assign gate_src[1]    = i_hcsl_source;
  assign gate_src[2]    = i_hcsl_source;
  assign gate_enable[0] = i_ref_enable_pin & ref_byte[`REF_ENABLE_BIT];
  assign gate_enable[1] = i_hcsl_a_enable_pin & hcsl_byte[`HCSL_A_ENABLE_BIT];
  assign gate_enable[2] = i_hcsl_b_enable_pin & hcsl_byte[`HCSL_B_ENABLE_BIT];

  genvar n;
  generate
    for (n = 0; n < 3; n = n + 1)
    begin : g_gate
      clean_clock_gate u_gate (
        .i_clk    (i_clk),
        .i_srst   (i_srst),
        .i_src    (gate_src[n]),
        .i_enable (gate_enable[n]),
        .o_clk    (gate_out[n])
      );
    end
  endgenerate

  assign o_ref_clk    = gate_out[0];
  assign o_hcsl_out_a = gate_out[1];
  assign o_hcsl_out_b = gate_out[2];

endmodule // clock_output_config_regs

// >>> pkg/clock_output_config_regs.vh
// register map, field positions, reset values and codes for the clock output config block
// Function
// - byte 1 spare, read/write, resets zero
// - byte 2 bit 7 gates output A
// - byte 2 bit 6 gates output B
// - byte 2 resets 0xc0, low bits reserved
// - byte 3 holds revision and maker nibbles
// - byte 4 transfer length, resets to six
// - byte 5 bit 7 selects programmed swing
// - swing codes map 300 to 1000 mV
// - byte 5 resets to 0xd8
// - reference output follows its enable pin
// - output A follows its enable pin
// - output B follows its enable pin
// - latch select pins, set rate mode
// - reference output derived from crystal input
// - select 00/01/10/11 picks 100/100ss/125/200 MHz
// - target address 0xd6, byte and block access
// - byte 0 bit 2 enables reference output
// - disabled output stops cleanly, held low
`ifndef CLOCK_OUTPUT_CONFIG_REGS_VH
`define CLOCK_OUTPUT_CONFIG_REGS_VH

`define NUM_REG_BYTES      6
`define TARGET_ADDR7       7'h6b
`define OFS_REF_ENABLE     8'h00
`define OFS_SPARE          8'h01
`define OFS_HCSL_ENABLES   8'h02
`define OFS_REVISION_MAKER 8'h03
`define OFS_TRANSFER_LEN   8'h04
`define OFS_SWING_CONTROL  8'h05

`define RST_REF_ENABLE     8'h04
`define RST_SPARE          8'h00
`define RST_HCSL_ENABLES   8'hc0
`define RST_TRANSFER_LEN   8'h06
`define RST_SWING_CONTROL  8'hd8

`define REF_ENABLE_BIT     2
`define HCSL_A_ENABLE_BIT  7
`define HCSL_B_ENABLE_BIT  6
`define SWING_SELECT_BIT   7
`define SWING_CODE_MSB     6
`define SWING_CODE_LSB     4

`define SWING_BASE_MV      10'h12c
`define SWING_STEP_MV      10'h064
`define SWING_DEFAULT_MV   10'h2bc

`define CMD_BYTE_MODE_BIT  7
`define CMD_INDEX_MSB      6

`define SEL_100_PLAIN      2'h0
`define SEL_100_SPREAD     2'h1
`define SEL_125            2'h2
`define SEL_200            2'h3
`define FREQ_100           2'h0
`define FREQ_125           2'h1
`define FREQ_200           2'h2

`endif

// >>> rtl/config_byte_store.v
// configuration byte store with reset image and registered read port
module config_byte_store #(
  parameter                          NUM_BYTES   = 6,
  parameter [8*NUM_BYTES-1:0]        RESET_IMAGE = {8*NUM_BYTES{1'b0}}
) (
  // clock and reset
  input  wire                        i_clk,
  input  wire                        i_srst,
  // write port
  input  wire                        i_wr_en,
  input  wire [7:0]                  i_wr_index,
  input  wire [7:0]                  i_wr_data,
  // read port
  input  wire [7:0]                  i_rd_index,
  output reg  [7:0]                  o_rd_data,
  output wire [8*NUM_BYTES-1:0]      o_image
);

  wire [8*NUM_BYTES-1:0] masked;
  reg  [7:0]             next_rd_data;
  integer                k;

  genvar g;
  generate
    for (g = 0; g < NUM_BYTES; g = g + 1)
    begin : g_byte
      localparam [31:0] IDX_WIDE = g;
      localparam [7:0]  IDX      = IDX_WIDE[7:0];
      reg [7:0] value;
      always @(posedge i_clk)
      begin
        if (i_srst)
          value <= RESET_IMAGE[8*g +: 8];
        else if (i_wr_en && i_wr_index == IDX)
          value <= i_wr_data;
      end
      assign o_image[8*g +: 8] = value;
      assign masked[8*g +: 8]  = (i_rd_index == IDX) ? value : 8'h00;
    end
  endgenerate

  // unmapped indices read as zero
  always @*
  begin
    next_rd_data = 8'h00;
    for (k = 0; k < NUM_BYTES; k = k + 1)
      next_rd_data = next_rd_data | masked[8*k +: 8];
  end

  always @(posedge i_clk)
  begin
    if (i_srst)
      o_rd_data <= 8'h00;
    else
      o_rd_data <= next_rd_data;
  end

endmodule // config_byte_store

// >>> rtl/clean_clock_gate.v
// glitch-free clock gate: enable changes only while the source is low
module clean_clock_gate (
  // clock and reset
  input  wire i_clk,
  input  wire i_srst,
  // source and enable
  input  wire i_src,
  input  wire i_enable,
  // gated output
  output reg  o_clk
);

  reg gate_open;

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      gate_open <= 1'b0;
      o_clk     <= 1'b0;
    end
    else
    begin
      if (!i_src)
        gate_open <= i_enable;
      o_clk <= i_src & gate_open;
    end
  end

endmodule // clean_clock_gate

// >>> tb/clock_output_config_regs_checker.sv
// assertion checker bound to the clock output configuration block
module clock_output_config_regs_checker (
  input wire       i_clk,
  input wire       i_srst,
  input wire       i_scl,
  input wire       o_sda_out,
  input wire       o_sda_oe,
  input wire       i_ref_enable_pin,
  input wire       i_hcsl_b_enable_pin,
  input wire       i_crystal_or_clock_input,
  input wire       i_hcsl_source,
  input wire       o_ref_clk,
  input wire       o_hcsl_out_a,
  input wire       o_hcsl_out_b,
  input wire [1:0] o_freq_code,
  input wire       o_spread_enable,
  input wire [9:0] o_swing_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sda_never_high_a: assert property (o_sda_out == 1'b0)
    else $error("data line driven high");
  sda_edge_scl_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data line moved while serial clock high");
  ref_start_clean_a: assert property ($rose(o_ref_clk) |->
    $past(i_crystal_or_clock_input) && !$past(i_crystal_or_clock_input, 2))
    else $error("reference output started with a short pulse");
  a_stop_clean_a: assert property ($fell(o_hcsl_out_a) |-> !$past(i_hcsl_source))
    else $error("output a stopped with a short pulse");
  b_disabled_low_a: assert property ((!i_hcsl_b_enable_pin) [*8] |-> !o_hcsl_out_b)
    else $error("output b runs with its pin low");
  ref_disabled_low_a: assert property ((!i_ref_enable_pin) [*8] |-> !o_ref_clk)
    else $error("reference output runs with its pin low");
  mode_held_a: assert property (!$past(i_srst) && !$past(i_srst, 2) && !$past(i_srst, 3) |->
    $stable(o_freq_code) && $stable(o_spread_enable))
    else $error("rate mode changed after capture");
  spread_only_100_a: assert property (o_spread_enable |-> o_freq_code == 2'h0)
    else $error("spread with a rate other than 100");
  swing_range_a: assert property (o_swing_mv >= 10'h12c && o_swing_mv <= 10'h3e8
    && o_swing_mv % 10'h064 == 10'h000)
    else $error("swing outside the code table");
  reset_quiet_a: assert property ($fell(i_srst) |->
    !o_sda_oe && !o_hcsl_out_a && !o_ref_clk && o_swing_mv == 10'h2bc)
    else $error("outputs not at reset values after release");
endmodule // clock_output_config_regs_checker

bind clock_output_config_regs clock_output_config_regs_checker chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_scl(i_scl), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .i_ref_enable_pin(i_ref_enable_pin), .i_hcsl_b_enable_pin(i_hcsl_b_enable_pin),
  .i_crystal_or_clock_input(i_crystal_or_clock_input), .i_hcsl_source(i_hcsl_source),
  .o_ref_clk(o_ref_clk), .o_hcsl_out_a(o_hcsl_out_a), .o_hcsl_out_b(o_hcsl_out_b),
  .o_freq_code(o_freq_code), .o_spread_enable(o_spread_enable), .o_swing_mv(o_swing_mv));

// >>> tb/i2c_host_model.sv
// serial bus controller model that drives the target port
module i2c_host_model (
  input  wire  i_clk,
  input  wire  i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // four system clocks a phase, above the three the target needs
  task automatic hp;
    repeat (4) @(negedge i_clk);
  endtask
  // data moves only while the serial clock is low
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = ~b;
    hp;
    o_scl = 1'b1;
    hp;
    r = i_sda;
    o_scl = 1'b0;
    hp;
  endtask
  // also a repeated start from a low clock
  task automatic start_cond;
    o_sda_low = 1'b0;
    hp;
    o_scl = 1'b1;
    hp;
    o_sda_low = 1'b1;
    hp;
    o_scl = 1'b0;
    hp;
  endtask
  task automatic stop_cond;
    o_sda_low = 1'b1;
    hp;
    o_scl = 1'b1;
    hp;
    o_sda_low = 1'b0;
    hp;
  endtask
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule // i2c_host_model

// >>> tb/tb.sv
// self-checking bench for the clock output configuration block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] REV   = 4'h2;
  localparam logic [3:0] MAKER = 4'h9; // arbitrary value
  logic       i_clk, i_srst, i_ref_enable_pin, i_hcsl_a_enable_pin, i_hcsl_b_enable_pin;
  logic       i_rate_select_low, i_rate_select_high, scl, host_low, ack;
  logic       o_sda_out, o_sda_oe, o_ref_clk, o_hcsl_out_a, o_hcsl_out_b, o_spread_enable;
  logic [1:0] o_freq_code;
  logic [9:0] o_swing_mv;
  logic [2:0] cnt = 3'h0;
  logic [7:0] regs [0:5];
  logic [7:0] d;
  int         seed, n_errors, compares;
  // pull-up on the data line
  wire        sda = ~(host_low | o_sda_oe);

  clock_output_config_regs #(.REVISION_CODE(REV), .MAKER_CODE(MAKER)) DUT (
    .i_clk(i_clk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .i_ref_enable_pin(i_ref_enable_pin), .i_hcsl_a_enable_pin(i_hcsl_a_enable_pin),
    .i_hcsl_b_enable_pin(i_hcsl_b_enable_pin), .i_rate_select_low(i_rate_select_low),
    .i_rate_select_high(i_rate_select_high), .i_crystal_or_clock_input(cnt[0]), .i_hcsl_source(cnt[1]),
    .o_ref_clk(o_ref_clk), .o_hcsl_out_a(o_hcsl_out_a), .o_hcsl_out_b(o_hcsl_out_b),
    .o_freq_code(o_freq_code), .o_spread_enable(o_spread_enable), .o_swing_mv(o_swing_mv));
  i2c_host_model host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(negedge i_clk) cnt <= cnt + 3'h1;

  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic send(input logic [7:0] b, input logic exp_ack);
    host.write_byte(b, ack);
    check("ack", {9'h0, exp_ack}, {9'h0, ack});
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    host.start_cond;
    send(8'hd6, 1'b1);
    send(8'h80 | idx, 1'b1);
    send(v, 1'b1);
    host.stop_cond;
    if (idx < 8'h06)
      regs[idx] = v;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] v);
    host.start_cond;
    send(8'hd6, 1'b1);
    send(8'h80 | idx, 1'b1);
    host.start_cond;
    send(8'hd7, 1'b1);
    host.read_byte(1'b1, v);
    host.stop_cond;
  endtask
  task automatic do_reset(input logic [1:0] sel);
    {i_rate_select_high, i_rate_select_low} = sel;
    i_srst = 1'b1;
    repeat (12) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (4) @(negedge i_clk);
    regs = '{8'h04, 8'h00, 8'hc0, {REV, MAKER}, 8'h06, 8'hd8};
  endtask
  function automatic logic [9:0] exp_swing(input logic [7:0] b);
    return b[7] ? 10'h12c + 10'h064 * b[6:4] : 10'h2bc;
  endfunction
  // result is {rate code, spread}
  function automatic logic [2:0] exp_mode(input logic [1:0] sel);
    return (sel == 2'h3) ? 3'h4 : (sel == 2'h2) ? 3'h2 : {2'h0, sel[0]};
  endfunction
  task automatic check_runs;
    logic [2:0] seen;
    seen = 3'h0;
    repeat (12) @(negedge i_clk);
    repeat (16)
    begin
      @(negedge i_clk);
      seen = seen | {o_ref_clk, o_hcsl_out_a, o_hcsl_out_b};
    end
    check("runs", {7'h0, i_ref_enable_pin & regs[0][2], i_hcsl_a_enable_pin & regs[2][7],
      i_hcsl_b_enable_pin & regs[2][6]}, {7'h0, seen});
  endtask

  initial
  begin
    repeat (100000) @(posedge i_clk);
    n_errors++;
    finish_test;
  end
  initial
  begin
    seed = 17125;
    n_errors = 0;
    compares = 0;
    {i_ref_enable_pin, i_hcsl_a_enable_pin, i_hcsl_b_enable_pin} = 3'h7;
    for (int k = 0; k < 4; k++)
    begin
      do_reset(k[1:0]);
      check("mode", {7'h0, exp_mode(k[1:0])}, {7'h0, o_freq_code, o_spread_enable});
      {i_rate_select_high, i_rate_select_low} = ~k[1:0];
      repeat (4) @(negedge i_clk);
      check("mode held", {7'h0, exp_mode(k[1:0])}, {7'h0, o_freq_code, o_spread_enable});
    end
    check("swing", 10'h320, o_swing_mv);
    host.start_cond;
    send(8'hd4, 1'b0);
    host.stop_cond;
    d = $random(seed);
    wr(8'h06, d);
    for (int i = 0; i < 7; i++)
    begin
      rd(i[7:0], d);
      check("reset value", {2'h0, (i < 6) ? regs[i] : 8'h00}, {2'h0, d});
    end
    d = $random(seed);
    wr(8'h01, d);
    rd(8'h01, d);
    check("spare", {2'h0, regs[1]}, {2'h0, d});
    for (int c = 0; c < 9; c++)
    begin
      d = $random(seed);
      d[7] = (c < 8);
      d[6:4] = c[2:0];
      wr(8'h05, d);
      check("swing", exp_swing(regs[5]), o_swing_mv);
    end
    host.start_cond;
    send(8'hd6, 1'b1);
    send(8'h01, 1'b1);
    send(8'h03, 1'b1);
    for (int i = 1; i < 4; i++)
    begin
      regs[i] = $random(seed);
      send(regs[i], 1'b1);
    end
    send(8'h5a, 1'b0);
    host.stop_cond;
    host.start_cond;
    send(8'hd6, 1'b1);
    send(8'h01, 1'b1);
    host.start_cond;
    send(8'hd7, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      host.read_byte(i == 4, d);
      check("block read", {2'h0, (i == 0) ? regs[4] : regs[i]}, {2'h0, d});
    end
    host.stop_cond;
    for (int t = 0; t < 8; t++)
    begin
      d = $random(seed);
      wr(8'h00, d);
      wr(8'h02, {t[0], t[1], d[5:0]});
      {i_ref_enable_pin, i_hcsl_a_enable_pin, i_hcsl_b_enable_pin} = {t[2], ~t[1:0]};
      check_runs;
    end
    finish_test;
  end
endmodule // tb
